//--- hw/mss_pkg.sv
// Shared constants, register map and carrier types of the soft start sequencer.
// Assumes a 200 MHz system clock and classic Wishbone with 32-bit data.
package mss_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_TIME_NS    = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned KICK_MAX_S    = 2;
  localparam logic [11:0] KICK_MAX_MS   = 12'(KICK_MAX_S * MS_PER_S);
  localparam logic [3:0]  DETECT_CYCLES = 4'h8;

  // ---------------------------------------------------------------
  // Levels, in percent of rated voltage
  // ---------------------------------------------------------------
  localparam logic [7:0]  RATED_LVL     = 8'h64;
  localparam logic [7:0]  ZERO_LVL      = 8'h00;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL      = 8'h00;
  localparam logic [7:0]  ADR_LEVELS    = 8'h04;
  localparam logic [7:0]  ADR_TIMES     = 8'h08;
  localparam logic [7:0]  ADR_FAULT     = 8'h0c;
  localparam logic [7:0]  ADR_STATUS    = 8'h10;

  localparam int unsigned CTRL_CLIMIT   = 0;
  localparam int unsigned CTRL_EDGE     = 1;
  localparam int unsigned CTRL_AUTO     = 2;
  localparam int unsigned CTRL_PREQ     = 3;
  localparam int unsigned CTRL_SHUNT    = 4;
  localparam int unsigned CTRL_STOP_LSB = 5;
  localparam int unsigned CTRL_MASK_LSB = 8;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_077f;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0002;

  localparam int unsigned START_LSB     = 0;
  localparam int unsigned KTRQ_LSB      = 8;
  localparam logic [31:0] LEVELS_WMASK  = 32'h0000_ffff;
  localparam logic [31:0] LEVELS_RST    = 32'h0000_5028;

  localparam int unsigned RAMP_LSB      = 0;
  localparam int unsigned KTIME_LSB     = 16;
  localparam logic [31:0] TIMES_WMASK   = 32'h0fff_ffff;
  localparam logic [31:0] TIMES_RST     = 32'h0000_2710;

  localparam int unsigned FLT_PHASE     = 0;
  localparam int unsigned FLT_ZC        = 1;
  localparam int unsigned FLT_EXT       = 2;
  localparam int unsigned FLT_W         = 3;

  localparam int unsigned ST_LVL_LSB    = 8;
  localparam int unsigned ST_UPANEL     = 16;
  localparam int unsigned ST_CPANEL     = 17;
  localparam int unsigned ST_READY      = 18;
  localparam int unsigned ST_BYPASS     = 19;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    S_IDLE   = 3'h0,
    S_KICK   = 3'h1,
    S_RAMP   = 3'h3,
    S_FINISH = 3'h2,
    S_BYPASS = 3'h6,
    S_CLIMIT = 3'h7
  } mss_state_t;

  typedef struct packed
  {
    logic permissive;
    logic start_command_input;
    logic line_present;
    logic zero_cross;
    logic sync_speed;
    logic user_panel_module;
    logic control_panel_module;
    logic ext_fault;
  } mss_pins_t;

  typedef struct packed
  {
    logic       fire_en;
    logic       bypass;
    logic [7:0] level;
  } mss_pole_t;

endpackage

//--- hw/mss_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes every bit is a slow level from outside the clock domain.
`timescale 1ns/10ps
module mss_sync
  #(parameter int unsigned W = 8)
   (input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] dout);

  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

//--- hw/mss_tick.sv
// Divider giving a one-cycle enable pulse every CYCLES clocks.
// Assumes CYCLES is at least 2.
`timescale 1ns/10ps
module mss_tick
  #(parameter int unsigned CYCLES = 200000)
   (input  wire logic clk,
    input  wire logic reset,
    output      logic tick);

  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

endmodule

//--- hw/mss_top.sv
// Soft start sequencer: kick, voltage ramp or current limit, then bypass.
// Assumes a 200 MHz clk, synchronous reset and a classic Wishbone master.
// Operation
// - Ramp from start level to rated exactly
// - Sync speed early finishes ramp, then bypass
// - Close pole bypass contacts at rated speed; ramp mode closes them at rated level without waiting for sync speed
// - Vary thyristor conduction to raise voltage gradually
// - Optional kick pulse, two seconds at most
// - Kick torque and time; zero time disables
// - Current limit holds constant start level voltage
// - Panel presence optionally required for operation
// - Detect user or control panel at power-up
// - Parameters kept in main board registers
// - Edge mode: no line at power-up faults
// - Level mode starts when line arrives later
// - Shunt trip output on selected faults
// - Permissive loss stops the motor
// - Start edge with permissive begins start
// - Edge mode needs start recycled after trip
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module mss_top
  import mss_pkg::*;
  #(parameter int unsigned MS_CYCLES_P = MS_CYCLES)
   (input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [31:0] wb_dat_w,
    input  wire logic [3:0]  wb_sel,
    output      logic [31:0] wb_dat_r,
    output      logic        wb_ack,
    input  wire mss_pins_t   pins,
    output      mss_pole_t   [2:0] pole_cmd,
    output      logic        shunt_trip,
    output      logic        ready_led);

  mss_pins_t        pins_s;
  logic             ms_tick;
  logic [31:0]      ctrl_q;
  logic [31:0]      levels_q;
  logic [31:0]      times_q;
  logic [FLT_W-1:0] fault_q;
  logic [FLT_W-1:0] fault_set;
  logic [FLT_W-1:0] fault_clr;
  logic [FLT_W-1:0] fault_cond;
  logic [FLT_W-1:0] shunt_mask;
  logic [3:0]       det_cnt_q;
  logic             por_done_q;
  logic             por_chk;
  logic             upanel_q;
  logic             cpanel_q;
  logic             tripped_q;
  logic             start_prev_q;
  logic             start_rise;
  logic             wb_req;
  logic             wb_wr;
  logic [31:0]      rd_d;
  logic             climit_mode;
  logic             edge_mode;
  logic             auto_reset;
  logic             panel_req;
  logic             shunt_en;
  logic [7:0]       start_lvl;
  logic [7:0]       kick_trq;
  logic [7:0]       span;
  logic [15:0]      ramp_ms;
  logic [11:0]      kick_raw;
  logic [11:0]      kick_len;
  logic             ready;
  logic             run_ok;
  logic             go;
  logic             running;
  mss_state_t       state_q;
  mss_state_t       first_st;
  logic [7:0]       lvl_q;
  logic [15:0]      elapsed_q;
  logic [16:0]      err_q;
  logic [16:0]      ramp_ext;
  logic [11:0]      kick_cnt_q;

  // ---------------------------------------------------------------
  // Pin synchroniser and millisecond enable
  // ---------------------------------------------------------------
  mss_sync #(.W($bits(mss_pins_t))) u_sync
  (
    .clk   (clk),
    .reset (reset),
    .din   (pins),
    .dout  (pins_s)
  );

  mss_tick #(.CYCLES(MS_CYCLES_P)) u_tick
  (
    .clk   (clk),
    .reset (reset),
    .tick  (ms_tick)
  );

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  assign climit_mode = ctrl_q[CTRL_CLIMIT];
  assign edge_mode   = ctrl_q[CTRL_EDGE];
  assign auto_reset  = ctrl_q[CTRL_AUTO];
  assign panel_req   = ctrl_q[CTRL_PREQ];
  assign shunt_en    = ctrl_q[CTRL_SHUNT];
  assign shunt_mask  = ctrl_q[CTRL_MASK_LSB +: FLT_W];
  assign start_lvl   = (levels_q[START_LSB +: 8] > RATED_LVL) ? RATED_LVL
                                                               : levels_q[START_LSB +: 8];
  assign kick_trq    = (levels_q[KTRQ_LSB +: 8] > RATED_LVL) ? RATED_LVL
                                                              : levels_q[KTRQ_LSB +: 8];
  assign span        = RATED_LVL - start_lvl;
  assign ramp_ms     = times_q[RAMP_LSB +: 16];
  assign ramp_ext    = {1'b0, ramp_ms};
  assign kick_raw    = times_q[KTIME_LSB +: 12];
  assign kick_len    = (kick_raw > KICK_MAX_MS) ? KICK_MAX_MS : kick_raw;
  assign first_st    = climit_mode ? S_CLIMIT : S_RAMP;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wb_req = wb_cyc & wb_stb & ~wb_ack;
  assign wb_wr  = wb_req & wb_we;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (wb_adr == ADR_CTRL)
    begin
      rd_d = ctrl_q;
    end
    else if (wb_adr == ADR_LEVELS)
    begin
      rd_d = levels_q;
    end
    else if (wb_adr == ADR_TIMES)
    begin
      rd_d = times_q;
    end
    else if (wb_adr == ADR_FAULT)
    begin
      rd_d[FLT_W-1:0] = fault_q;
    end
    else if (wb_adr == ADR_STATUS)
    begin
      rd_d[2:0]              = state_q;
      rd_d[ST_LVL_LSB +: 8]  = lvl_q;
      rd_d[ST_UPANEL]        = upanel_q;
      rd_d[ST_CPANEL]        = cpanel_q;
      rd_d[ST_READY]         = ready;
      rd_d[ST_BYPASS]        = (state_q == S_BYPASS);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end
    else
    begin
      wb_ack <= wb_req;
      if (wb_req && !wb_we)
      begin
        wb_dat_r <= rd_d;
      end
    end
  end

  // Parameters live here; panel edits arrive over the bus
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_q   <= CTRL_RST;
      levels_q <= LEVELS_RST;
      times_q  <= TIMES_RST;
    end
    else if (wb_wr && wb_adr == ADR_CTRL)
    begin
      ctrl_q <= wb_merge(ctrl_q, wb_dat_w, wb_sel) & CTRL_WMASK;
    end
    else if (wb_wr && wb_adr == ADR_LEVELS)
    begin
      levels_q <= wb_merge(levels_q, wb_dat_w, wb_sel) & LEVELS_WMASK;
    end
    else if (wb_wr && wb_adr == ADR_TIMES)
    begin
      times_q <= wb_merge(times_q, wb_dat_w, wb_sel) & TIMES_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // Power-up panel detection and line check
  // ---------------------------------------------------------------
  assign por_chk = ~por_done_q & (det_cnt_q == DETECT_CYCLES);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      det_cnt_q  <= 4'h0;
      por_done_q <= 1'b0;
      upanel_q   <= 1'b0;
      cpanel_q   <= 1'b0;
    end
    else if (!por_done_q)
    begin
      det_cnt_q <= det_cnt_q + 4'h1;
      if (por_chk)
      begin
        por_done_q <= 1'b1;
        upanel_q   <= pins_s.user_panel_module;
        cpanel_q   <= pins_s.control_panel_module;
      end
    end
  end

  // ---------------------------------------------------------------
  // Faults; a new event wins over a clear
  // ---------------------------------------------------------------
  assign running    = (state_q != S_IDLE);
  assign fault_cond = {pins_s.ext_fault, ~pins_s.zero_cross, ~pins_s.line_present};
  assign fault_set[FLT_PHASE] = ~pins_s.line_present & (running | (por_chk & edge_mode));
  assign fault_set[FLT_ZC]    = ~pins_s.zero_cross & (running | (por_chk & edge_mode));
  assign fault_set[FLT_EXT]   = pins_s.ext_fault;
  assign fault_clr = ((wb_wr && wb_adr == ADR_FAULT && wb_sel[0]) ? wb_dat_w[FLT_W-1:0]
                                                                   : {FLT_W{1'b0}})
                   | (auto_reset ? ~fault_cond : {FLT_W{1'b0}});

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fault_q <= {FLT_W{1'b0}};
    end
    else
    begin
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  // ---------------------------------------------------------------
  // Start qualification
  // ---------------------------------------------------------------
  assign start_rise = pins_s.start_command_input & ~start_prev_q;
  assign ready  = por_done_q & ~|fault_q & pins_s.permissive & pins_s.line_present
                & (~panel_req | upanel_q);
  assign run_ok = pins_s.permissive & ~|fault_q;
  assign go = (state_q == S_IDLE) & ready
            & (edge_mode ? start_rise
                         : (start_rise | (pins_s.start_command_input
                                          & (auto_reset | ~tripped_q))));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_prev_q <= 1'b0;
      tripped_q    <= 1'b0;
    end
    else
    begin
      start_prev_q <= pins_s.start_command_input;
      if (|fault_set)
      begin
        tripped_q <= 1'b1;
      end
      else if (go)
      begin
        tripped_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Start sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q    <= S_IDLE;
      lvl_q      <= ZERO_LVL;
      elapsed_q  <= 16'h0000;
      err_q      <= 17'h0_0000;
      kick_cnt_q <= 12'h000;
    end
    else if (running && !run_ok)
    begin
      state_q <= S_IDLE;
      lvl_q   <= ZERO_LVL;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (go)
          begin
            elapsed_q  <= 16'h0000;
            err_q      <= 17'h0_0000;
            kick_cnt_q <= 12'h000;
            if (kick_len != 12'h000)
            begin
              state_q <= S_KICK;
              lvl_q   <= kick_trq;
            end
            else
            begin
              state_q <= first_st;
              lvl_q   <= start_lvl;
            end
          end
        end
        S_KICK:
        begin
          if (ms_tick)
          begin
            if (kick_cnt_q + 12'h001 >= kick_len)
            begin
              state_q <= first_st;
              lvl_q   <= start_lvl;
            end
            else
            begin
              kick_cnt_q <= kick_cnt_q + 12'h001;
            end
          end
        end
        S_RAMP:
        begin
          if (pins_s.sync_speed)
          begin
            state_q <= S_FINISH;
          end
          else if (ramp_ms == 16'h0000 || (elapsed_q == ramp_ms && err_q < ramp_ext))
          begin
            state_q <= S_FINISH;
          end
          else if (ms_tick && elapsed_q != ramp_ms)
          begin
            elapsed_q <= elapsed_q + 16'h0001;
            err_q     <= err_q + {9'h000, span};
          end
          else if (err_q >= ramp_ext)
          begin
            err_q <= err_q - ramp_ext;
            lvl_q <= lvl_q + 8'h01;
          end
        end
        S_FINISH:
        begin
          if (lvl_q >= RATED_LVL)
          begin
            state_q <= S_BYPASS;
            lvl_q   <= RATED_LVL;
          end
          else
          begin
            lvl_q <= lvl_q + 8'h01;
          end
        end
        S_CLIMIT:
        begin
          if (pins_s.sync_speed)
          begin
            state_q <= S_BYPASS;
            lvl_q   <= RATED_LVL;
          end
        end
        S_BYPASS:
        begin
          state_q <= S_BYPASS;
        end
        default:
        begin
          state_q <= S_IDLE;
          lvl_q   <= ZERO_LVL;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pole, shunt trip and ready outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pole_cmd   <= '0;
      shunt_trip <= 1'b0;
      ready_led  <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
      begin
        pole_cmd[p].fire_en <= running && state_q != S_BYPASS;
        pole_cmd[p].bypass  <= (state_q == S_BYPASS);
        pole_cmd[p].level   <= lvl_q;
      end
      shunt_trip <= shunt_en & |(fault_q & shunt_mask);
      ready_led  <= ready;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ramp_exact_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_RAMP && run_ok && !pins_s.sync_speed && ramp_ms != 16'h0000
      && elapsed_q == ramp_ms && err_q < ramp_ext |=> state_q == S_FINISH && lvl_q == RATED_LVL)
    else $error("Ramp did not end at rated level");
  sync_early_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_RAMP && run_ok && pins_s.sync_speed |=> state_q == S_FINISH)
    else $error("Sync speed did not finish ramp");
  pole_bypass_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_BYPASS |=> pole_cmd[0].bypass && pole_cmd[2].bypass && !pole_cmd[1].fire_en)
    else $error("Bypass contacts not closed");
  level_rise_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_RAMP && run_ok |=> lvl_q >= $past(lvl_q))
    else $error("Ramp level fell");
  kick_bound_a:
    assert property (@(posedge clk) disable iff (reset) kick_cnt_q < KICK_MAX_MS)
    else $error("Kick longer than limit");
  kick_skip_a:
    assert property (@(posedge clk) disable iff (reset)
      go && kick_len == 12'h000 |=> state_q != S_KICK)
    else $error("Kick with zero time");
  climit_hold_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_CLIMIT && run_ok && !pins_s.sync_speed |=> state_q == S_CLIMIT && $stable(lvl_q))
    else $error("Current limit level moved");
  panel_need_a:
    assert property (@(posedge clk) disable iff (reset) panel_req && !upanel_q |-> !ready)
    else $error("Ready without required panel");
  por_fault_a:
    assert property (@(posedge clk) disable iff (reset)
      por_chk && edge_mode && !pins_s.line_present |=> fault_q[FLT_PHASE] ##1 !ready_led)
    else $error("Missing line not faulted");
  level_start_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_IDLE && ready && !edge_mode && auto_reset && pins_s.start_command_input
      |=> state_q != S_IDLE)
    else $error("Level start not taken");
  shunt_out_a:
    assert property (@(posedge clk) disable iff (reset)
      shunt_en && |(fault_q & shunt_mask) |=> shunt_trip)
    else $error("Shunt trip not driven");
  perm_stop_a:
    assert property (@(posedge clk) disable iff (reset)
      running && !pins_s.permissive |=> state_q == S_IDLE ##1 !pole_cmd[0].fire_en)
    else $error("Permissive loss did not stop");
  edge_start_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_IDLE && ready && start_rise |=> state_q != S_IDLE)
    else $error("Start edge ignored");
  edge_hold_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_IDLE && edge_mode && start_prev_q |=> state_q == S_IDLE)
    else $error("Held start restarted in edge mode");
  climit_byp_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_CLIMIT && run_ok && pins_s.sync_speed |=> state_q == S_BYPASS)
    else $error("Current limit did not bypass");
  ramp_byp_a:
    assert property (@(posedge clk) disable iff (reset)
      state_q == S_FINISH && run_ok && lvl_q >= RATED_LVL |=> state_q == S_BYPASS)
    else $error("Ramp end did not bypass");

endmodule

//--- testbench/mss_motor_model.sv
// Motor behind the poles: reports sync speed after a set firing time.
// Assumes phase one stands for all poles; load contactor is always closed.
`timescale 1ns/10ps
module mss_motor_model
  import mss_pkg::*;
  (input  wire logic        clk,
   input  wire mss_pole_t   pole,
   input  wire logic [15:0] sync_after,
   output      logic        sync_speed);
  logic [15:0] cnt_q;
  logic        on;
  assign on = pole.fire_en | pole.bypass;
  always_ff @(posedge clk)
    if (!on)
      cnt_q <= 16'h0000;
    else if (cnt_q != 16'hffff)
      cnt_q <= cnt_q + 16'h0001;
  assign sync_speed = (sync_after != 16'h0000) && (cnt_q >= sync_after) && on;
endmodule

//--- testbench/motor_soft_start_sequencer_tb_top.sv
// Self-checking bench of the soft start sequencer.
// Assumes the motor model answers sync speed; Wishbone master is local.
`timescale 1ns/10ps
module motor_soft_start_sequencer_tb_top;
  import mss_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] x;} mss_row_t;
  mss_row_t rows [4] = '{'{ADR_CTRL, CTRL_RST}, '{ADR_LEVELS, LEVELS_RST},
                         '{ADR_TIMES, TIMES_RST}, '{8'h14, 32'h0000_0000}};
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, perm = 1, start = 0, line = 1;
  logic ack, shunt, rdy, sync;
  logic [7:0] adr = 0, p;
  logic [31:0] dw = 0, dr, q;
  logic [3:0] sel = 0;
  logic [15:0] sy = 0;
  mss_pins_t pins;
  mss_pole_t [2:0] pole;
  int err_count = 0, comparisons = 0, i, n;
  assign pins = '{perm, start, line, 1'b1, sync, 1'b1, 1'b0, 1'b0};
  always #2.5 clk = ~clk;
  mss_top #(.MS_CYCLES_P(20)) uut (.clk(clk), .reset(reset), .wb_cyc(cyc), .wb_stb(stb),
    .wb_we(we), .wb_adr(adr), .wb_dat_w(dw), .wb_sel(sel), .wb_dat_r(dr), .wb_ack(ack),
    .pins(pins), .pole_cmd(pole), .shunt_trip(shunt), .ready_led(rdy));
  mss_motor_model motor (.clk(clk), .pole(pole[0]), .sync_after(sy), .sync_speed(sync));
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task tmo(input int c, input int m);
    if (c >= m)
    begin
      chk("wait", 1, 0);
      report_and_stop;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hf};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    q = dr;
    tmo(n, 20);
    {cyc, stb} <= 2'b00;
  endtask
  task go(input logic [15:0] s);
    sy <= s;
    start <= 1;
    repeat (4) @(posedge clk);
    start <= 0;
    for (n = 0; n < 40 && pole[0].fire_en !== 1'b1; n++)
      @(posedge clk);
    tmo(n, 40);
  endtask
  task run;
    p = 0;
    for (n = 0; n < 200 && pole[0].bypass !== 1'b1; n++)
    begin
      @(posedge clk);
      if (pole[0].fire_en === 1'b1)
      begin
        if (pole[0].level < p)
          chk("rising", 1, 0);
        p = pole[0].level;
      end
    end
    tmo(n, 200);
  endtask
  task halt;
    repeat (2) @(posedge clk);
    chk("bypass", 32'h1, {pole[0].fire_en, pole[0].bypass});
    chk("poles", 32'(pole[0]), 32'(pole[2]));
    perm <= 0;
    repeat (6) @(posedge clk);
    chk("coast", 0, 32'(pole));
    perm <= 1;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    chk("reset", 0, 32'(pole));
    @(posedge clk);
    reset <= 0;
    repeat (14) @(posedge clk);
    chk("ready", 1, rdy);
    for (i = 0; i < 4; i++)
    begin
      wb(0, rows[i].a, 0);
      chk("reg", rows[i].x, q);
    end
    wb(0, ADR_STATUS, 0);
    chk("panels", 32'h0005_0000, q & 32'h0007_0000);
    wb(1, ADR_TIMES, 32'h0000_0005);
    go(0);
    chk("start lvl", 32'h28, pole[0].level);
    run;
    chk("ramp time", 1, 32'(n >= 75));
    chk("end lvl", 32'h64, p);
    halt;
    wb(1, ADR_TIMES, 32'h0000_03e8);
    go(30);
    run;
    chk("early lvl", 32'h64, p);
    halt;
    wb(1, ADR_TIMES, 32'h0002_0005);
    go(0);
    chk("kick lvl", 32'h50, pole[0].level);
    for (n = 0; n < 60 && pole[0].level === 8'h50; n++)
      @(posedge clk);
    chk("kick len", 1, 32'(n >= 20 && n <= 45));
    run;
    halt;
    wb(1, ADR_TIMES, 32'h0000_0005);
    wb(1, ADR_CTRL, 32'h0000_0003);
    go(60);
    run;
    chk("climit sync", 1, 32'(n >= 50));
    chk("climit lvl", 32'h28, p);
    halt;
    line <= 0;
    reset <= 1;
    repeat (5) @(posedge clk);
    reset <= 0;
    repeat (20) @(posedge clk);
    wb(0, ADR_FAULT, 0);
    chk("phase loss", 1, 32'(q[FLT_PHASE]));
    wb(1, ADR_CTRL, 32'h0000_0112);
    repeat (3) @(posedge clk);
    chk("shunt on", 1, shunt);
    wb(1, ADR_FAULT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("shunt off", 0, shunt);
    wb(1, ADR_CTRL, 32'h0000_0004);
    start <= 1;
    repeat (4) @(posedge clk);
    line <= 1;
    for (n = 0; n < 20 && pole[0].fire_en !== 1'b1; n++)
      @(posedge clk);
    chk("level start", 1, pole[0].fire_en);
    report_and_stop;
  end
endmodule
